/* File: core/sys_break_lowpower_reset_status.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// Operation
// - Break request forces software-interrupt vector fetch
// - Clear enable low blocks flag clears in break
// - Clear enable high lets clears stick
// - Two-step clears stay protected across break
// - Wait or stop clears interrupt mask
// - Wait gates processor clocks, peripherals run
// - Enabled interrupt wakes wait, stack next cycle
// - Reset or break ends wait; break sets flag
// - Watchdog runs in wait unless disabled
// - Stop resets counter, disables clock output
// - Stop exits; stacking waits for recovery
// - Recovery 4096 cycles, or 32 if short
// - Counter held in stop, then times recovery
// - Registers at FE00, FE01, FE03
// - Break-exited-wait flag readable, set by break
// - Reading reset register clears its flags
// - Power-on sets only the power-on flag
// - Uncleared earlier flags accumulate with new
// - Drive reset pin low, sample 32 later
// - One flag per reset source
// - Monitor-entry reset sets its own flag
module sys_break_lowpower_reset_status (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire sysint_pkg::reg_req_t   i_req,
	output logic [7:0]                  o_rdata,
	input  wire logic                   i_break_req,
	input  wire logic                   i_wait_exec,
	input  wire logic                   i_stop_exec,
	input  wire logic                   i_irq_pending,
	input  wire logic                   i_short_stop_recovery,
	input  wire logic                   i_watchdog_disable_option,
	input  wire logic                   i_flag_clear_req,
	input  wire logic                   i_two_step_first,
	input  wire logic                   i_two_step_second,
	input  wire sysint_pkg::reset_cause_t i_reset_cause,
	input  wire logic                   i_internal_reset,
	input  wire logic                   i_reset_pin,
	output logic                        o_reset_pin_out,
	output logic                        o_reset_pin_oe,
	output logic                        o_force_swi_vector,
	output logic                        o_clear_mask,
	output logic                        o_cpu_clk_en,
	output logic                        o_periph_clk_en,
	output logic                        o_clock_gen_output_en,
	output logic                        o_stack_start,
	output logic                        o_watchdog_run,
	output logic                        o_flag_clear_allow,
	output logic                        o_two_step_clear,
	output logic                        o_break_mode
);
	import sysint_pkg::*;

	power_state_t           state;
	power_state_t           next_state;
	logic [COUNT_W-1:0]     counter;
	logic [COUNT_W-1:0]     recover_limit;
	logic                   clear_enable;
	logic                   break_mode;
	logic                   break_wait_flag;
	logic [7:0]             reset_source;
	logic                   two_step_armed;
	logic [2:0]             pin_sync;
	logic [5:0]             pin_count;
	logic                   pin_sampling;
	logic                   pin_low_seen;
	logic                   stack_pending;
	logic                   bus_break_read;

	// Recovery length picked by the option bit
	assign recover_limit = i_short_stop_recovery
		? COUNT_W'(STOP_SHORT_CYCLES - 1)
		: COUNT_W'(STOP_LONG_CYCLES - 1);

	// Power state sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (i_stop_exec)
					next_state = ST_STOP;
				else if (i_wait_exec)
					next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (i_irq_pending || i_break_req)
					next_state = ST_RUN;
			end
			ST_STOP: begin
				if (i_irq_pending || i_break_req)
					next_state = ST_RECOVER;
			end
			ST_RECOVER: begin
				if (counter == recover_limit)
					next_state = ST_RUN;
			end
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			state <= ST_RUN;
		else if (i_internal_reset)
			state <= ST_RUN;
		else
			state <= next_state;
	end

	// Counter held clear in stop, counts only during recovery
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			counter <= '0;
		else if (state != ST_RECOVER)
			counter <= '0;
		else
			counter <= counter + COUNT_W'(1);
	end

	// Stacking waits one cycle after wake-up from wait or stop
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			stack_pending <= 1'b0;
		else
			stack_pending <= (state != ST_RUN) && (next_state == ST_RUN)
				&& i_irq_pending && !i_break_req;
	end
	assign o_stack_start = stack_pending;

	// Clock gating; stop kills the generator so peripherals halt too
	assign o_cpu_clk_en          = (state == ST_RUN);
	assign o_periph_clk_en       = (state == ST_RUN) || (state == ST_WAIT);
	assign o_clock_gen_output_en = (state != ST_STOP);
	assign o_clear_mask          = (state == ST_RUN) && (i_wait_exec || i_stop_exec);
	assign o_watchdog_run        = !i_watchdog_disable_option
		&& (state == ST_RUN || state == ST_WAIT);

	// Break mode lasts until a write clears it or reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			break_mode <= 1'b0;
		else if (i_break_req)
			break_mode <= 1'b1;
		else if (i_internal_reset)
			break_mode <= 1'b0;
		else if (i_req.wr && i_req.addr == BREAK_STATUS_ADDR)
			break_mode <= 1'b0;
	end
	assign o_force_swi_vector = i_break_req;
	assign o_break_mode       = break_mode;

	// Clear enable register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			clear_enable <= CLEAR_ENABLE_INIT;
		else if (i_req.wr && i_req.addr == BREAK_CONTROL_ADDR)
			clear_enable <= i_req.wdata[CLEAR_ENABLE_BIT];
	end

	// Flag clears pass only outside break, or with clear enable set
	assign o_flag_clear_allow = i_flag_clear_req
		&& (!break_mode || clear_enable);

	// Two-step sequence: armed by the first step, wherever it fell
	// A blocked second step must not disarm, or the pending clear is lost
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			two_step_armed <= 1'b0;
		else if (i_two_step_first)
			two_step_armed <= 1'b1;
		else if (o_two_step_clear)
			two_step_armed <= 1'b0;
	end
	assign o_two_step_clear = i_two_step_second && two_step_armed
		&& (!break_mode || clear_enable);

	// Break-exited-wait flag: set wins over clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			break_wait_flag <= BREAK_STATUS_INIT[BREAK_WAIT_BIT];
		else if (state == ST_WAIT && i_break_req)
			break_wait_flag <= 1'b1;
		else if (i_req.wr && i_req.addr == BREAK_STATUS_ADDR
			&& !i_req.wdata[BREAK_WAIT_BIT])
			break_wait_flag <= 1'b0;
	end

	// Reset pin sampler, three stages
	// Starts at the pulled-up idle level so no false low follows reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			pin_sync <= 3'h7;
		else
			pin_sync <= {pin_sync[1:0], i_reset_pin};
	end

	// Pin driven low during internal reset, sampled 32 cycles after
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_sampling <= 1'b1;
			pin_count    <= '0;
		end else if (i_internal_reset) begin
			pin_sampling <= 1'b1;
			pin_count    <= '0;
		end else if (pin_sampling) begin
			pin_count <= pin_count + 6'(1);
			if (pin_count == 6'(PIN_SAMPLE_CYCLES - 1))
				pin_sampling <= 1'b0;
		end
	end
	assign pin_low_seen    = pin_sampling && pin_count == 6'(PIN_SAMPLE_CYCLES - 1)
		&& !pin_sync[2] && !pin_sync[1];
	assign o_reset_pin_out = 1'b0;
	assign o_reset_pin_oe  = !i_internal_reset;

	// Reset source flags: read clears, new causes accumulate
	assign bus_break_read = i_req.rd && i_req.addr == RESET_SOURCE_ADDR;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			reset_source <= RESET_SOURCE_POR;
		else if (i_reset_cause.por)
			reset_source <= RESET_SOURCE_POR;
		else begin
			reset_source <= (bus_break_read ? 8'h00 : reset_source)
				| ({7'h00, 1'b0} << 0)
				| (8'(i_reset_cause.watchdog)      << RST_WDOG_BIT)
				| (8'(i_reset_cause.illegal_op)    << RST_ILLEGAL_OPCODE_RESET_FLAG_BIT)
				| (8'(i_reset_cause.illegal_addr)  << RST_ILLEGAL_ADDRESS_RESET_FLAG_BIT)
				| (8'(i_reset_cause.low_voltage)   << RST_LVI_BIT)
				| (8'(i_reset_cause.monitor_entry) << RST_MODE_BIT)
				| (8'(i_reset_cause.pin || pin_low_seen) << RST_PIN_BIT);
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_req.rd) begin
			case (i_req.addr)
				BREAK_STATUS_ADDR:  o_rdata <= 8'(break_wait_flag) << BREAK_WAIT_BIT;
				RESET_SOURCE_ADDR:  o_rdata <= reset_source;
				BREAK_CONTROL_ADDR: o_rdata <= 8'(clear_enable) << CLEAR_ENABLE_BIT;
				default:            o_rdata <= 8'h00;
			endcase
		end else
			o_rdata <= 8'h00;
	end

	// Checks
	chk_clear_blocked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(break_mode && !clear_enable) |-> !o_flag_clear_allow)
		else $error("flag clear passed while protected");
	chk_clear_allowed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(break_mode && clear_enable && i_flag_clear_req) |-> o_flag_clear_allow)
		else $error("enabled clear blocked in break");
	chk_stop_clock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_STOP) |-> (!o_clock_gen_output_en && counter == '0))
		else $error("stop left clock or counter running");
	chk_wait_clock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_WAIT) |-> (!o_cpu_clk_en && o_periph_clk_en))
		else $error("wait clock gating wrong");
	chk_short_recover: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		($rose(state == ST_RECOVER) && i_short_stop_recovery && !i_internal_reset)
		|-> ##32 (state == ST_RUN))
		else $error("short recovery length wrong");
	chk_break_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_WAIT && i_break_req) |=> break_wait_flag)
		else $error("break in wait not flagged");
	chk_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(bus_break_read && i_reset_cause == '0 && !pin_low_seen) |=> reset_source == 8'h00)
		else $error("reset source not cleared by read");
	chk_por_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_reset_cause.por |=> reset_source == RESET_SOURCE_POR)
		else $error("power-on flag wrong");
	chk_mask_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_RUN && i_wait_exec) |-> o_clear_mask)
		else $error("mask not cleared");
	// Break request steers the core to the software-interrupt vector
	chk_swi_vector: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_break_req |-> o_force_swi_vector)
		else $error("break did not force vector");
	// Break request enters break mode on the next edge
	chk_break_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_break_req |=> break_mode)
		else $error("break mode not entered");
	// Blocked second step keeps the sequence armed
	chk_two_step_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_two_step_second && two_step_armed && break_mode && !clear_enable)
		|=> two_step_armed)
		else $error("blocked second step disarmed");
	// Outside break an armed second step clears
	chk_two_step_pass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_two_step_second && two_step_armed && !break_mode) |-> o_two_step_clear)
		else $error("second step did not clear");
	// Stop clears the mask as wait does
	chk_stop_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_RUN && i_stop_exec) |-> o_clear_mask)
		else $error("mask not cleared on stop");
	// Interrupt in wait starts stacking one cycle later
	chk_wait_wake: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_WAIT && i_irq_pending && !i_break_req) |=> o_stack_start)
		else $error("wait wake did not stack");
	// Break ends wait
	chk_wait_exit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_WAIT && i_break_req) |=> state == ST_RUN)
		else $error("break did not end wait");
	// Watchdog keeps running in wait unless the option disables it
	chk_watchdog_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_WAIT && !i_watchdog_disable_option) |-> o_watchdog_run)
		else $error("watchdog stopped in wait");
	// Stop halts the core and the peripherals alike
	chk_stop_halt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_STOP) |-> (!o_cpu_clk_en && !o_periph_clk_en))
		else $error("clocks running in stop");
	// Clock generator only off in stop
	chk_clock_back: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state != ST_STOP) |-> o_clock_gen_output_en)
		else $error("clock generator off outside stop");
	// No stacking before the recovery count is out
	chk_recover_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_RECOVER && counter != recover_limit) |=> !o_stack_start)
		else $error("stacking before recovery end");
	// Full recovery never ends before its last count
	chk_long_recover: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_RECOVER && !i_short_stop_recovery && !i_internal_reset
		&& counter < COUNT_W'(STOP_LONG_CYCLES - 1)) |=> state == ST_RECOVER)
		else $error("full recovery cut short");
	// Counter steps once per cycle through recovery
	chk_counter_runs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(state == ST_RECOVER && next_state == ST_RECOVER && !i_internal_reset)
		|=> counter == $past(counter) + COUNT_W'(1))
		else $error("recovery counter stalled");
	// Low pin at the sample point sets the pin flag
	chk_pin_sample: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(pin_low_seen && !i_reset_cause.por) |=> reset_source[RST_PIN_BIT])
		else $error("pin flag not set");
	// Pin pulled low for the whole internal reset
	chk_pin_driven: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_internal_reset |-> (!o_reset_pin_oe && !o_reset_pin_out))
		else $error("reset pin not driven low");
	// Watchdog reset has its own flag
	chk_cause_wdog: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_reset_cause.watchdog && !i_reset_cause.por) |=> reset_source[RST_WDOG_BIT])
		else $error("watchdog flag not set");
	// Illegal opcode reset has its own flag
	chk_cause_illop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_reset_cause.illegal_op && !i_reset_cause.por) |=> reset_source[RST_ILLEGAL_OPCODE_RESET_FLAG_BIT])
		else $error("illegal opcode flag not set");
	// Monitor-entry reset has its own flag
	chk_cause_monitor: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_reset_cause.monitor_entry && !i_reset_cause.por) |=> reset_source[RST_MODE_BIT])
		else $error("monitor entry flag not set");
	// Unread flags are lost only to a power-on reset
	chk_flags_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!bus_break_read && !i_reset_cause.por)
		|=> (reset_source & $past(reset_source)) == $past(reset_source))
		else $error("unread reset flag lost");
	// Read data only in the cycle after a read strobe
	chk_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!$past(i_req.rd) |-> o_rdata == 8'h00)
		else $error("read data outside its cycle");
	// Clear enable follows its write
	chk_enable_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_req.wr && i_req.addr == BREAK_CONTROL_ADDR)
		|=> clear_enable == $past(i_req.wdata[CLEAR_ENABLE_BIT]))
		else $error("clear enable write lost");
	// Break-exited-wait flag readable at its bit
	chk_flag_readback: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_req.rd && i_req.addr == BREAK_STATUS_ADDR)
		|=> o_rdata[BREAK_WAIT_BIT] == $past(break_wait_flag))
		else $error("break wait flag read wrong");
	// Main scenarios for coverage
	cov_wait_wake: cover property (@(posedge i_clk) state == ST_WAIT ##1 o_stack_start);
	cov_break_wait: cover property (@(posedge i_clk) state == ST_WAIT && i_break_req);
	cov_short_rec: cover property (@(posedge i_clk)
		state == ST_RECOVER && i_short_stop_recovery ##1 state == ST_RUN);
	cov_stop_wake: cover property (@(posedge i_clk) state == ST_RECOVER ##1 state == ST_RUN);
	cov_break_prot: cover property (@(posedge i_clk) break_mode && i_flag_clear_req);

endmodule // sys_break_lowpower_reset_status

/* File: core/sysint_pkg.sv */
package sysint_pkg;

	// Register map (byte addresses on the 16-bit bus)
	localparam logic [15:0] BREAK_STATUS_ADDR  = 16'hFE00;
	localparam logic [15:0] RESET_SOURCE_ADDR  = 16'hFE01;
	localparam logic [15:0] BREAK_CONTROL_ADDR = 16'hFE03;

	// Field positions
	localparam int BREAK_WAIT_BIT   = 1;
	localparam int CLEAR_ENABLE_BIT = 7;
	localparam int RST_LVI_BIT      = 1;
	localparam int RST_MODE_BIT     = 2;
	localparam int RST_ILLEGAL_ADDRESS_RESET_FLAG_BIT     = 3;
	localparam int RST_ILLEGAL_OPCODE_RESET_FLAG_BIT     = 4;
	localparam int RST_WDOG_BIT     = 5;
	localparam int RST_PIN_BIT      = 6;
	localparam int RST_POR_BIT      = 7;

	// Values after reset
	localparam logic [7:0] RESET_SOURCE_POR  = 8'h80;
	localparam logic [7:0] BREAK_STATUS_INIT = 8'h00;
	localparam logic       CLEAR_ENABLE_INIT = 1'b0;

	// Counts of cycles
	localparam int STOP_LONG_CYCLES  = 4096;
	localparam int STOP_SHORT_CYCLES = 32;
	localparam int PIN_SAMPLE_CYCLES = 32;
	localparam int COUNT_W           = 13;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_WAIT    = 2'b01,
		ST_STOP    = 2'b11,
		ST_RECOVER = 2'b10
	} power_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic por;
		logic pin;
		logic watchdog;
		logic illegal_op;
		logic illegal_addr;
		logic monitor_entry;
		logic low_voltage;
	} reset_cause_t;

endpackage

/* File: testbench/cpu_core_model.sv */
`timescale 1ns/10ps
// Core side: issues low-power instructions and picks the stop recovery option
module cpu_core_model (
	input  wire logic       i_cpu_clk_en,
	input  wire logic [1:0] i_cmd,
	input  wire logic       i_canned_osc,
	output logic            o_wait_exec,
	output logic            o_stop_exec,
	output logic            o_short_rec
);
	// A gated core fetches nothing, so no instruction can issue then
	assign o_wait_exec = i_cpu_clk_en && (i_cmd == 2'h1);
	assign o_stop_exec = i_cpu_clk_en && (i_cmd == 2'h2);
	// Crystals need the full start-up, only a canned oscillator may shorten it
	assign o_short_rec = i_canned_osc;
endmodule // cpu_core_model

/* File: testbench/sys_break_lowpower_reset_status_test.sv */
`timescale 1ns/10ps
module sys_break_lowpower_reset_status_test;
	import sysint_pkg::*;
	logic         i_clk = 1'b0, i_rst_n = 1'b0, i_break_req = 1'b0, i_irq_pending = 1'b0;
	logic         i_watchdog_disable_option = 1'b0, i_flag_clear_req = 1'b0;
	logic         i_two_step_first = 1'b0, i_two_step_second = 1'b0, i_internal_reset = 1'b0;
	logic         ext_pin = 1'b1, canned = 1'b0, rd_q = 1'b0;
	logic [1:0]   cmd = 2'h0;
	reg_req_t     i_req = '0;
	reset_cause_t i_reset_cause = '0;
	logic [7:0]   o_rdata, v, a, b;
	logic         o_reset_pin_out, o_reset_pin_oe, o_force_swi_vector, o_clear_mask;
	logic         o_cpu_clk_en, o_periph_clk_en, o_clock_gen_output_en, o_stack_start;
	logic         o_watchdog_run, o_flag_clear_allow, o_two_step_clear, o_break_mode;
	logic         i_wait_exec, i_stop_exec, i_short_stop_recovery;
	logic [7:0]   exp_q[$];
	int           errors = 0, checked = 0, n, len;
	// Pin has a pull-up outside; the block pulls it low with enable low
	wire logic    i_reset_pin = o_reset_pin_oe ? ext_pin : o_reset_pin_out;

	sys_break_lowpower_reset_status i_dut (.i_clk, .i_rst_n, .i_req, .o_rdata, .i_break_req,
		.i_wait_exec, .i_stop_exec, .i_irq_pending, .i_short_stop_recovery,
		.i_watchdog_disable_option, .i_flag_clear_req, .i_two_step_first, .i_two_step_second,
		.i_reset_cause, .i_internal_reset, .i_reset_pin, .o_reset_pin_out, .o_reset_pin_oe,
		.o_force_swi_vector, .o_clear_mask, .o_cpu_clk_en, .o_periph_clk_en,
		.o_clock_gen_output_en, .o_stack_start, .o_watchdog_run, .o_flag_clear_allow,
		.o_two_step_clear, .o_break_mode);
	cpu_core_model i_core (.i_cpu_clk_en(o_cpu_clk_en), .i_cmd(cmd), .i_canned_osc(canned),
		.o_wait_exec(i_wait_exec), .o_stop_exec(i_stop_exec), .o_short_rec(i_short_stop_recovery));

	// Clock
	initial begin
		forever #5 i_clk = ~i_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Bus cycles end with a gap edge so no strobe is driven twice in one step
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		i_req <= '{ad, d, 1'b1, 1'b0};
		@(posedge i_clk);
		i_req <= '0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		i_req <= '{ad, 8'h00, 1'b0, 1'b1};
		@(posedge i_clk);
		i_req <= '0;
		@(posedge i_clk);
	endtask

	task automatic cause(input logic [6:0] c);
		i_reset_cause <= c;
		@(posedge i_clk);
		i_reset_cause <= '0;
		@(posedge i_clk);
	endtask

	// Counts edges until stacking starts, bounded so a lost wake cannot hang
	task automatic wait_stack(input int lim);
		n = 0;
		while (o_stack_start !== 1'b1 && n < lim) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		@(posedge i_clk);
		i_irq_pending <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge i_clk) rd_q <= i_req.rd;
	always @(negedge i_clk) if (rd_q) chk(o_rdata, exp_q.pop_front(), "read");

	// Watchdog, well beyond the longest stop recovery
	initial begin
		#300000;
		errors++;
		end_sim();
	end

	initial begin
		v = 8'($urandom(43551));
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rd(RESET_SOURCE_ADDR, RESET_SOURCE_POR);
		rd(RESET_SOURCE_ADDR, 8'h00);
		rd(BREAK_CONTROL_ADDR, 8'h00);
		rd(BREAK_STATUS_ADDR, BREAK_STATUS_INIT);
		rd(16'hFE02, 8'h00);
		// Every source but power-on alone, then random pairs that pile up unread
		for (int k = 0; k < 6; k++) begin
			cause(7'(1 << k));
			rd(RESET_SOURCE_ADDR, 8'(2 << k));
		end
		a = 8'($urandom_range(1, 63));
		b = 8'($urandom_range(1, 63));
		cause(a[6:0]);
		cause(b[6:0]);
		rd(RESET_SOURCE_ADDR, {a[6:0] | b[6:0], 1'b0});
		cause(7'h10);
		cause(7'h40);
		rd(RESET_SOURCE_ADDR, RESET_SOURCE_POR);
		// Internal reset pulls the pin; pin level is sampled later
		for (int p = 0; p < 2; p++) begin
			ext_pin <= 1'(p);
			i_internal_reset <= 1'b1;
			repeat (2) @(posedge i_clk);
			chk(o_reset_pin_oe, 8'h00, "pin oe");
			chk(i_reset_pin, 8'h00, "pin level");
			i_internal_reset <= 1'b0;
			repeat (40) @(posedge i_clk);
			ext_pin <= 1'b1;
			rd(RESET_SOURCE_ADDR, p ? 8'h00 : 8'h40);
		end
		// Break with protection on, first step of a two-step clear before entry
		i_two_step_first <= 1'b1;
		@(posedge i_clk);
		i_two_step_first <= 1'b0;
		i_break_req <= 1'b1;
		@(posedge i_clk);
		chk(o_force_swi_vector, 8'h01, "swi vector");
		@(posedge i_clk);
		i_flag_clear_req <= 1'b1;
		i_two_step_second <= 1'b1;
		#1;
		chk(o_flag_clear_allow, 8'h00, "clear blocked");
		chk(o_two_step_clear, 8'h00, "two-step blocked");
		@(posedge i_clk);
		i_flag_clear_req <= 1'b0;
		i_two_step_second <= 1'b0;
		i_break_req <= 1'b0;
		@(posedge i_clk);
		wr(BREAK_CONTROL_ADDR, v | 8'h80);
		rd(BREAK_CONTROL_ADDR, 8'h80);
		i_flag_clear_req <= 1'b1;
		#1;
		chk(o_flag_clear_allow, 8'h01, "clear enabled");
		@(posedge i_clk);
		i_flag_clear_req <= 1'b0;
		wr(BREAK_CONTROL_ADDR, 8'h00);
		wr(BREAK_STATUS_ADDR, 8'h00);
		i_two_step_second <= 1'b1;
		#1;
		chk(o_two_step_clear, 8'h01, "two-step after");
		@(posedge i_clk);
		i_two_step_second <= 1'b0;
		// Wait entered and woken by interrupt, watchdog option both ways
		for (int d = 0; d < 2; d++) begin
			i_watchdog_disable_option <= 1'(d);
			cmd <= 2'h1;
			#1;
			chk(o_clear_mask, 8'h01, "mask wait");
			@(posedge i_clk);
			cmd <= 2'h0;
			#1;
			chk({o_cpu_clk_en, o_periph_clk_en}, 8'h01, "wait clocks");
			chk(o_watchdog_run, 8'(d == 0), "watchdog");
			@(posedge i_clk);
			i_irq_pending <= 1'b1;
			wait_stack(10);
			chk(8'(n >= 1 && n <= 2), 8'h01, "wait stack");
		end
		// Break ends wait and leaves its flag
		cmd <= 2'h1;
		@(posedge i_clk);
		cmd <= 2'h0;
		i_break_req <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk(o_cpu_clk_en, 8'h01, "break wake");
		i_break_req <= 1'b0;
		rd(BREAK_STATUS_ADDR, 8'h02);
		wr(BREAK_STATUS_ADDR, 8'h00);
		rd(BREAK_STATUS_ADDR, 8'h00);
		// Stop with short recovery, then the full one
		for (int s = 1; s >= 0; s--) begin
			canned <= 1'(s);
			len = s ? STOP_SHORT_CYCLES : STOP_LONG_CYCLES;
			cmd <= 2'h2;
			#1;
			chk(o_clear_mask, 8'h01, "mask stop");
			@(posedge i_clk);
			cmd <= 2'h0;
			repeat (3) @(posedge i_clk);
			chk({o_clock_gen_output_en, o_periph_clk_en}, 8'h00, "stop clocks");
			i_irq_pending <= 1'b1;
			wait_stack(5000);
			chk(8'(n >= len && n <= len + 4), 8'h01, "stop recovery");
			chk(o_clock_gen_output_en, 8'h01, "clock back");
		end
		repeat (3) @(posedge i_clk);
		end_sim();
	end
endmodule // sys_break_lowpower_reset_status_test
